// >>> src/bce_core.sv
// Purpose : Executes option load, return with literal, sleep,
//           rotate through carry and subtract on an 8-bit core
// Assumes : APB slave, one wait state on every access
// Notes   : Instructions are issued by writing the command word
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module bce_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        wake_req,
  input  wire logic        pin_change_wake,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  option_out,
  output logic      [8:0]  pc_out,
  output logic             osc_halt,
  output logic             busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bce_pkg::bce_state_type state_reg;
  bce_pkg::bce_state_type state_next;
  bce_pkg::bce_instr_type instr_reg;
  bce_pkg::bce_flags_type flags_reg;

  logic [7:0]  acc_reg;
  logic [7:0]  option_reg;
  logic [8:0]  pc_reg;
  logic [8:0]  stack_reg [2];
  logic [7:0]  wdt_reg;
  logic [7:0]  wdt_pre_reg;
  logic [15:0] cycles_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  logic        acc_phase;
  logic        wr_done;
  logic        sel_file;
  logic        sel_cmd;
  logic        cmd_ok;
  logic        issue;
  logic        exec;

  logic [7:0]  f_val;
  logic [7:0]  result;
  logic        res_carry;
  logic        res_dc;
  logic        upd_carry;
  logic        upd_dc_z;
  logic        to_file;
  logic        to_acc;
  logic [8:0]  diff;

  logic        fw_en;
  logic [4:0]  fw_addr;
  logic [7:0]  fw_data;
  logic [4:0]  fr_addr;
  logic [7:0]  fr_data;
  logic [31:0] rd_word;
  logic        addr_ok;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign acc_phase = psel && penable;
  assign wr_done   = acc_phase && pready_reg && pwrite;
  assign sel_file  = paddr[7];
  assign sel_cmd   = (paddr == bce_pkg::OFF_CMD);
  // A command while busy or asleep would corrupt the running one
  assign cmd_ok    = (state_reg == bce_pkg::ST_IDLE);
  assign issue     = wr_done && sel_cmd && cmd_ok && !pslverr_reg;
  assign exec      = (state_reg == bce_pkg::ST_EXEC);

  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (sel_file) begin
      addr_ok = (paddr[1:0] == 2'b00);
      rd_word = {24'h00_0000, fr_data};
    end else begin
      unique case (paddr)
        bce_pkg::OFF_CMD:    rd_word = {15'h0000, instr_reg};
        bce_pkg::OFF_ACC:    rd_word = {24'h00_0000, acc_reg};
        bce_pkg::OFF_OPTION: rd_word = {24'h00_0000, option_reg};
        bce_pkg::OFF_STATUS: rd_word = {22'h00_0000,
                                        state_reg == bce_pkg::ST_HALT,
                                        state_reg != bce_pkg::ST_IDLE,
                                        2'b00, flags_reg};
        bce_pkg::OFF_PC:     rd_word = {23'h00_0000, pc_reg};
        bce_pkg::OFF_STACK:  rd_word = {23'h00_0000, stack_reg[0]};
        bce_pkg::OFF_WDT:    rd_word = {16'h0000, wdt_pre_reg, wdt_reg};
        bce_pkg::OFF_CYCLES: rd_word = {16'h0000, cycles_reg};
        default:             addr_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, error on bad address or refused cmd
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      if (acc_phase && !pready_reg) begin
        pready_reg  <= 1'b1;
        pslverr_reg <= !addr_ok || (pwrite && sel_cmd && !cmd_ok);
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pready_reg  <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bce_pkg::ST_IDLE: begin
        if (issue) begin
          state_next = bce_pkg::ST_EXEC;
        end
      end
      bce_pkg::ST_EXEC: begin
        if (instr_reg.op == bce_pkg::OP_RET_LIT) begin
          state_next = bce_pkg::ST_FLUSH;
        end else if (instr_reg.op == bce_pkg::OP_SLEEP) begin
          state_next = bce_pkg::ST_HALT;
        end else begin
          state_next = bce_pkg::ST_IDLE;
        end
      end
      bce_pkg::ST_FLUSH: begin
        // Prefetched word is dropped here
        state_next = bce_pkg::ST_IDLE;
      end
      bce_pkg::ST_HALT: begin
        if (wake_req) begin
          state_next = bce_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= bce_pkg::ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= '0;
    end else if (ce && issue) begin
      instr_reg.op      <= bce_pkg::bce_op_type'(pwdata[bce_pkg::CMD_OP_LSB +: 3]);
      instr_reg.dest    <= pwdata[bce_pkg::CMD_DEST_BIT];
      instr_reg.faddr   <= pwdata[bce_pkg::CMD_FADDR_LSB +: 5];
      instr_reg.literal <= pwdata[bce_pkg::CMD_LIT_LSB +: 8];
    end
  end

  // Instruction cycles spent in execute and flush, not in halt; a two-cycle op adds two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles_reg <= 16'h0000;
    end else if (ce && (exec || state_reg == bce_pkg::ST_FLUSH)) begin
      cycles_reg <= cycles_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  assign fr_addr = exec ? instr_reg.faddr : paddr[6:2];
  assign f_val   = fr_data;
  assign diff    = {1'b0, f_val} - {1'b0, acc_reg};

  always_comb begin
    result    = f_val;
    res_carry = flags_reg.carry;
    res_dc    = flags_reg.digit_carry;
    upd_carry = 1'b0;
    upd_dc_z  = 1'b0;
    unique case (instr_reg.op)
      bce_pkg::OP_ROT_L: begin
        result    = {f_val[6:0], flags_reg.carry};
        res_carry = f_val[7];
        upd_carry = 1'b1;
      end
      bce_pkg::OP_ROT_R: begin
        result    = {flags_reg.carry, f_val[7:1]};
        res_carry = f_val[0];
        upd_carry = 1'b1;
      end
      bce_pkg::OP_SUB: begin
        result    = diff[7:0];
        res_carry = !diff[8];
        res_dc    = (f_val[3:0] >= acc_reg[3:0]);
        upd_carry = 1'b1;
        upd_dc_z  = 1'b1;
      end
      default: begin
        result = f_val;
      end
    endcase
  end

  assign to_file = exec && instr_reg.dest && upd_carry;
  assign to_acc  = exec && !instr_reg.dest && upd_carry;

  // Software writes share the port; never overlap since commands
  // and file writes are both APB transfers taken one at a time
  assign fw_en   = to_file || (wr_done && sel_file && addr_ok);
  assign fw_addr = exec ? instr_reg.faddr : paddr[6:2];
  assign fw_data = exec ? result : pwdata[7:0];

  bce_file_regs u_file (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr_en   (fw_en),
    .wr_addr (fw_addr),
    .wr_data (fw_data),
    .rd_addr (fr_addr),
    .rd_data (fr_data)
  );

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= bce_pkg::ACC_RST;
    end else if (ce) begin
      if (exec && instr_reg.op == bce_pkg::OP_RET_LIT) begin
        acc_reg <= instr_reg.literal;
      end else if (to_acc) begin
        acc_reg <= result;
      end else if (wr_done && paddr == bce_pkg::OFF_ACC) begin
        acc_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Option register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg <= bce_pkg::OPTION_RST;
    end else if (ce && exec && instr_reg.op == bce_pkg::OP_OPT_LOAD) begin
      option_reg <= acc_reg;
    end
  end

  // ----------------------------------------------------------------
  // Flags; option load and literal return leave them alone
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
      flags_reg.timeout   <= 1'b1;
      flags_reg.powerdown <= 1'b1;
    end else if (ce) begin
      flags_reg.wake <= pin_change_wake;
      if (exec && upd_carry) begin
        flags_reg.carry <= res_carry;
      end
      if (exec && upd_dc_z) begin
        flags_reg.digit_carry <= res_dc;
        flags_reg.zero        <= (result == 8'h00);
      end
      if (exec && instr_reg.op == bce_pkg::OP_SLEEP) begin
        flags_reg.timeout   <= 1'b1;
        flags_reg.powerdown <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and two-level return stack
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= bce_pkg::PC_RST;
    end else if (ce) begin
      if (exec && instr_reg.op == bce_pkg::OP_RET_LIT) begin
        pc_reg <= stack_reg[0];
      end else if (wr_done && paddr == bce_pkg::OFF_PC) begin
        pc_reg <= pwdata[8:0];
      end
    end
  end

  // A write to the stack word pushes; the return pops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_reg[0] <= bce_pkg::PC_RST;
      stack_reg[1] <= bce_pkg::PC_RST;
    end else if (ce) begin
      if (exec && instr_reg.op == bce_pkg::OP_RET_LIT) begin
        stack_reg[0] <= stack_reg[1];
      end else if (wr_done && paddr == bce_pkg::OFF_STACK) begin
        stack_reg[0] <= pwdata[8:0];
        stack_reg[1] <= stack_reg[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog: prescaler feeds the counter; halted with the clock
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pre_reg <= 8'h00;
      wdt_reg     <= 8'h00;
    end else if (ce) begin
      if (exec && instr_reg.op == bce_pkg::OP_SLEEP) begin
        wdt_pre_reg <= 8'h00;
        wdt_reg     <= 8'h00;
      end else if (state_reg != bce_pkg::ST_HALT) begin
        wdt_pre_reg <= wdt_pre_reg + 8'h01;
        if (wdt_pre_reg == 8'hff) begin
          wdt_reg <= wdt_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_halt <= 1'b0;
      busy     <= 1'b0;
    end else if (ce) begin
      osc_halt <= (state_next == bce_pkg::ST_HALT);
      busy     <= (state_next != bce_pkg::ST_IDLE);
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign option_out = option_reg;
  assign pc_out     = pc_reg;

endmodule

// >>> common/bce_pkg.sv
// Purpose : Constants and types for the baseline core execution subset
// Assumes : APB slave, 32-bit data, one clock pclk at 40 MHz
// Notes   : Offsets are byte addresses of aligned words
package bce_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W    = 9;
  localparam int WDT_W   = 8;
  localparam int PRE_W   = 8;
  localparam int CYC_W   = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ACC    = 8'h04;
  localparam logic [7:0] OFF_OPTION = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_STACK  = 8'h14;
  localparam logic [7:0] OFF_WDT    = 8'h18;
  localparam logic [7:0] OFF_CYCLES = 8'h1c;
  localparam logic [7:0] OFF_FILE   = 8'h80;

  // CMD word fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_DEST_BIT  = 3;
  localparam int CMD_FADDR_LSB = 4;
  localparam int CMD_LIT_LSB   = 16;

  // STATUS word bits
  localparam int ST_CARRY  = 0;
  localparam int ST_DIGIT_CARRY = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_WAKE   = 5;
  localparam int ST_BUSY   = 8;
  localparam int ST_SLEEP  = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [8:0] PC_RST     = 9'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP      = 3'b000,
    OP_OPT_LOAD = 3'b001,
    OP_RET_LIT  = 3'b010,
    OP_SLEEP    = 3'b011,
    OP_ROT_L    = 3'b100,
    OP_ROT_R    = 3'b101,
    OP_SUB      = 3'b110
  } bce_op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10,
    ST_HALT  = 2'b11
  } bce_state_type;

  typedef struct packed {
    logic [7:0]   literal;
    logic [4:0]   faddr;
    logic         dest;
    bce_op_type   op;
  } bce_instr_type;

  typedef struct packed {
    logic wake;
    logic timeout;
    logic powerdown;
    logic zero;
    logic digit_carry;
    logic carry;
  } bce_flags_type;

endpackage

// >>> src/bce_file_regs.sv
// Purpose : 32 x 8 file register array with one read and one write port
// Assumes : Write port owned by the execution core
// Notes   : Read is combinational from the array
`timescale 1ns/10ps
module bce_file_regs (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem_reg [32];

  // ----------------------------------------------------------------
  // Storage, one entry per generate slot
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 32; i++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_reg[i] <= 8'h00;
      end else if (ce && wr_en && (wr_addr == 5'(i))) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  assign rd_data = mem_reg[rd_addr];

endmodule

// >>> tb/bce_core_props.sv
// Purpose : Port-level assertions for the execution core
// Assumes : a single APB master; checks pause while ce is low
// Notes   : Bound into every bce_core instance
`timescale 1ns/10ps
module bce_core_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        wake_req,
  input wire logic        pin_change_wake,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  option_out,
  input wire logic [8:0]  pc_out,
  input wire logic        osc_halt,
  input wire logic        busy
);
  logic       wr_done;
  logic       cmd_ok;
  logic [2:0] cmd_op;

  assign wr_done = psel && penable && pready && pwrite;
  assign cmd_ok  = wr_done && !pslverr && paddr == bce_pkg::OFF_CMD;
  assign cmd_op  = pwdata[2:0];

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  // ----------------------------------------------------------------
  // Bus and instruction timing
  // ----------------------------------------------------------------
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  ret_two_cycles_a: assert property (
    cmd_ok && cmd_op == bce_pkg::OP_RET_LIT |=> busy [*2] ##1 !busy)
    else $error("return with literal did not take two cycles");
  one_cycle_ops_a: assert property (
    cmd_ok && cmd_op inside {bce_pkg::OP_OPT_LOAD, bce_pkg::OP_ROT_L, bce_pkg::OP_ROT_R,
    bce_pkg::OP_SUB} |=> busy ##1 !busy)
    else $error("single cycle instruction took the wrong time");
  // Sleep must reach the halt state straight from execution
  sleep_halt_a: assert property (
    cmd_ok && cmd_op == bce_pkg::OP_SLEEP |=> busy ##1 (osc_halt && busy))
    else $error("sleep did not halt the oscillator");
  halt_hold_a: assert property (osc_halt && !wake_req |=> osc_halt)
    else $error("left sleep without a wake request");
  halt_refuse_a: assert property (
    wr_done && paddr == bce_pkg::OFF_CMD && osc_halt && $past(osc_halt) |-> pslverr)
    else $error("command accepted while asleep");
  option_src_a: assert property ($changed(option_out) |-> $past(busy))
    else $error("option changed outside an instruction");
  pc_src_a: assert property (
    $changed(pc_out) |-> $past(busy) || $past(wr_done && paddr == bce_pkg::OFF_PC))
    else $error("program counter changed without cause");
endmodule

bind bce_core bce_core_props i_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake_req(wake_req),
  .pin_change_wake(pin_change_wake), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .option_out(option_out), .pc_out(pc_out),
  .osc_halt(osc_halt), .busy(busy)
);

// >>> tb/bce_core_bench.sv
// Purpose : Self-checking bench for the execution core over APB
// Assumes : ce high except in the enable test; CMD write layout as decoded
// Notes   : Expected values come from a small reference model below
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bce_core_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        wake_req = 1'b0;
  logic        pin_change_wake = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  option_out;
  logic [8:0]  pc_out;
  logic        osc_halt;
  logic        busy;
  int          n_fail = 0;
  int          n_checks = 0;
  int          i;
  // ----------------------------------------------------------------
  // Reference model state
  // ----------------------------------------------------------------
  logic [7:0]  acc = 8'h00;
  logic [7:0]  opt = 8'hff;
  logic [7:0]  fr [32];
  logic        c = 1'b0;
  logic        dig_c = 1'b0;
  logic        z = 1'b0;
  logic        pwr_dn = 1'b1;
  logic        t_out = 1'b1;
  logic [7:0]  pre0;
  logic [7:0]  pre1;
  logic [8:0]  stk;
  logic [15:0] cyc;
  logic [31:0] rd;
  logic        err;

  bce_core i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake_req(wake_req),
    .pin_change_wake(pin_change_wake), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .option_out(option_out), .pc_out(pc_out),
    .osc_halt(osc_halt), .busy(busy)
  );

  always #12.5 pclk = ~pclk;

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Idle cycle first, so psel is never assigned twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] fa(input logic [4:0] f);
    return bce_pkg::OFF_FILE + {1'b0, f, 2'b00};
  endfunction

  task automatic setf(input logic [4:0] f, input logic [7:0] v);
    apb(1'b1, fa(f), {24'h0, v});
    fr[f] = v;
  endtask

  task automatic seta(input logic [7:0] v);
    apb(1'b1, bce_pkg::OFF_ACC, {24'h0, v});
    acc = v;
  endtask

  task automatic exec(input bce_pkg::bce_op_type op, input logic d, input logic [4:0] f,
                      input logic [7:0] k);
    logic [7:0] r;
    int         n;
    r = fr[f];
    case (op)
      bce_pkg::OP_OPT_LOAD: opt = acc;
      bce_pkg::OP_RET_LIT: acc = k;
      bce_pkg::OP_SLEEP: begin
        t_out = 1'b1;
        pwr_dn = 1'b0;
      end
      bce_pkg::OP_ROT_L: begin
        r = {fr[f][6:0], c};
        c = fr[f][7];
      end
      bce_pkg::OP_ROT_R: begin
        r = {c, fr[f][7:1]};
        c = fr[f][0];
      end
      bce_pkg::OP_SUB: begin
        r = fr[f] - acc;
        c = fr[f] >= acc;
        dig_c = fr[f][3:0] >= acc[3:0];
        z = r == 8'h00;
      end
      default: ;
    endcase
    if (op == bce_pkg::OP_ROT_L || op == bce_pkg::OP_ROT_R || op == bce_pkg::OP_SUB) begin
      if (d)
        fr[f] = r;
      else
        acc = r;
    end
    apb(1'b1, bce_pkg::OFF_CMD, {8'h00, k, 7'h00, f, d, op});
    `CHK("cmd_err", 1'b0, err)
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && osc_halt !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_of_test;
    end
    apb(1'b0, bce_pkg::OFF_ACC, 32'h0);
    `CHK("acc", {24'h0, acc}, rd)
    apb(1'b0, fa(f), 32'h0);
    `CHK("file", {24'h0, fr[f]}, rd)
    apb(1'b0, bce_pkg::OFF_STATUS, 32'h0);
    `CHK("flags", {pin_change_wake, t_out, pwr_dn, z, dig_c, c}, rd[5:0])
    `CHK("state_bits", op == bce_pkg::OP_SLEEP ? 2'b11 : 2'b00, rd[9:8])
    `CHK("option", opt, option_out)
  endtask

  initial begin
    for (i = 0; i < 32; i++)
      fr[i] = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bce_pkg::OFF_STATUS, 32'h0);
    `CHK("status_rst", 32'h18, rd)
    `CHK("option_rst", 8'hff, option_out)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b0, 8'h81, 32'h0);
    `CHK("unaligned_err", 1'b1, err)
    $display("test reset done");
    seta(8'h5a);
    exec(bce_pkg::OP_OPT_LOAD, 1'b0, 5'd0, 8'h00);
    $display("test option done");
    for (i = 0; i < 2; i++) begin
      stk = i ? 9'h1ff : 9'h0a5;
      apb(1'b1, bce_pkg::OFF_STACK, {23'h0, stk});
      apb(1'b0, bce_pkg::OFF_CYCLES, 32'h0);
      cyc = rd[15:0];
      exec(bce_pkg::OP_RET_LIT, 1'b0, 5'd0, i ? 8'hff : 8'h00);
      `CHK("pc", stk, pc_out)
      apb(1'b0, bce_pkg::OFF_CYCLES, 32'h0);
      `CHK("cycles", cyc + 16'h0002, rd[15:0])
    end
    $display("test return done");
    setf(5'd31, 8'h81);
    exec(bce_pkg::OP_ROT_L, 1'b1, 5'd31, 8'h00);
    exec(bce_pkg::OP_ROT_R, 1'b0, 5'd31, 8'h00);
    setf(5'd0, 8'h80);
    exec(bce_pkg::OP_ROT_L, 1'b0, 5'd0, 8'h00);
    exec(bce_pkg::OP_ROT_R, 1'b1, 5'd0, 8'h00);
    $display("test rotate done");
    for (i = 0; i < 4; i++) begin
      setf(5'(i * 10), i == 0 ? 8'h10 : i == 1 ? 8'h05 : i == 2 ? 8'h00 : 8'hff);
      seta(i == 0 ? 8'h01 : i == 1 ? 8'h05 : i == 2 ? 8'h01 : 8'h00);
      exec(bce_pkg::OP_SUB, i[0], 5'(i * 10), 8'h00);
    end
    $display("test subtract done");
    // With ce low the prescaler must not count the extra cycles
    apb(1'b0, bce_pkg::OFF_WDT, 32'h0);
    pre0 = rd[15:8];
    apb(1'b0, bce_pkg::OFF_WDT, 32'h0);
    pre1 = rd[15:8];
    ce <= 1'b0;
    repeat (6) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, bce_pkg::OFF_WDT, 32'h0);
    `CHK("ce_freeze", 8'(pre1 - pre0), 8'(rd[15:8] - pre1))
    $display("test enable done");
    pin_change_wake <= 1'b1;
    i = 0;
    do begin
      apb(1'b0, bce_pkg::OFF_WDT, 32'h0);
      i++;
    end while (rd[7:0] === 8'h00 && i < 150);
    `CHK("wdt_running", 1'b1, rd[7:0] !== 8'h00)
    if (rd[7:0] === 8'h00)
      end_of_test;
    exec(bce_pkg::OP_SLEEP, 1'b0, 5'd0, 8'h00);
    `CHK("halted", 1'b1, osc_halt)
    apb(1'b0, bce_pkg::OFF_WDT, 32'h0);
    `CHK("wdt_clear", 16'h0000, rd[15:0])
    apb(1'b1, bce_pkg::OFF_CMD, 32'h0);
    `CHK("asleep_err", 1'b1, err)
    wake_req <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (osc_halt !== 1'b0 && i < 20);
    `CHK("woken", 1'b0, osc_halt)
    if (osc_halt !== 1'b0)
      end_of_test;
    wake_req <= 1'b0;
    seta(8'h3c);
    exec(bce_pkg::OP_OPT_LOAD, 1'b0, 5'd0, 8'h00);
    $display("test sleep done");
    end_of_test;
  end
endmodule
